/* File: common/hrce_pkg.sv */
package hrce_pkg;

  // ----------------------------------------------------------------
  // report framing
  // ----------------------------------------------------------------
  localparam int CMD_BYTES = 4;
  localparam int FULL_SPEED_REPORT_BYTES = 64;
  localparam int LOW_SPEED_REPORT_BYTES = 8;

  // ----------------------------------------------------------------
  // command identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_ERROR = 8'hFF;
  localparam logic [7:0] SERIAL_SETUP_CMD = 8'h93;
  localparam logic [7:0] ANALOG_SAMPLE_CMD = 8'h96;
  localparam logic [7:0] READ_REG_CMD = 8'h98;
  localparam logic [7:0] WRITE_REG_CMD = 8'h99;
  localparam logic [7:0] READ_REG_BIT_CMD = 8'h9A;
  localparam logic [7:0] WRITE_REG_BIT_CMD = 8'h9B;
  localparam logic [7:0] READ_IO_CMD = 8'h9C;
  localparam logic [7:0] WRITE_IO_CMD = 8'h9D;
  localparam logic [7:0] READ_IO_PIN_CMD = 8'h9E;
  localparam logic [7:0] WRITE_IO_PIN_CMD = 8'h9F;

  // ----------------------------------------------------------------
  // serial port setup registers and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SPI_SAMPLING_EDGE_SETUP_ADDR = 8'hE0;
  localparam logic [7:0] SPI_ENABLE_POLARITY_RATE_ADDR = 8'hE1;
  localparam logic [7:0] SPI_SAMPLING_EDGE_SETUP_RESET = 8'h00;
  localparam logic [7:0] SPI_ENABLE_POLARITY_RATE_RESET = 8'h00;
  localparam logic [7:0] SPI_SAMPLING_EDGE_SETUP_MASK = 8'hC0;
  localparam logic [7:0] SPI_ENABLE_POLARITY_RATE_MASK = 8'h33;
  localparam logic [1:0] SERIAL_MODE_SPI = 2'h0;
  localparam int SPI_SAMPLE_END_BIT = 7;
  localparam int SPI_TX_ACTIVE_IDLE_BIT = 6;
  localparam int SPI_ENABLE_BIT = 5;
  localparam int SPI_IDLE_HIGH_BIT = 4;

  // ----------------------------------------------------------------
  // io and analog
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_DIR_RESET = 8'hFF;
  localparam logic [7:0] IO_OUT_RESET = 8'h00;
  localparam int ADC_VREF_POS_BIT = 4;
  localparam int ADC_VREF_NEG_BIT = 5;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RX = 4'h0,
    ST_FETCH = 4'h1,
    ST_EXEC = 4'h2,
    ST_RDWAIT = 4'h3,
    ST_ADC = 4'h4,
    ST_WB = 4'h5,
    ST_TXRD = 4'h6,
    ST_TXLD = 4'h7,
    ST_TXOUT = 4'h8
  } hrce_state_e;

endpackage

/* File: common/hrce_mem_if.sv */
`timescale 1ns/1ps
interface hrce_mem_if #(parameter int AW = 6);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

/* File: rtl/hrce_report_mem.sv */
`timescale 1ns/1ps
module hrce_report_mem #(
  parameter int DEPTH = 64
) (
  // clock
  input wire logic mclk_i,
  // access port
  hrce_mem_if.mem m
);
  import hrce_pkg::*;

  // ----------------------------------------------------------------
  // storage, read data registered
  // ----------------------------------------------------------------
  logic [7:0] store [DEPTH];
  logic [7:0] rdata_reg;

  always_ff @(posedge mclk_i)
  begin
    if (m.we)
    begin
      store[m.waddr] <= m.wdata;
    end
    rdata_reg <= store[m.raddr];
  end

  assign m.rdata = rdata_reg;

endmodule // hrce_report_mem

/* File: rtl/hrce_engine.sv */
//Contract
// [R1] full speed: 64-byte reports both ways, 1 ms interval, endpoint 1.
// [R2] low speed: 8-byte reports both ways, 10 ms interval, endpoint 1.
// [R3] commands are four bytes; 16 slots full speed, 2 slots low speed.
// [R4] host pads unused report bytes with zero.
// [R5] slots execute strictly in order from the first.
// [R6] byte 0 is the identifier, bytes 1 to 3 the payload.
// [R7] long serial transfer commands only as sole command of a report.
// [R8] response repeats the identifier unless an error occurred.
// [R9] responses built in place; unused bytes keep the command value.
// [R10] identifier 0x00 does nothing and answers all zero.
// [R11] meaningless command answers 0xFF then command bytes 0 to 2.
// [R12] 0x98 reads register byte1 into byte2; 0x99 writes byte2.
// [R13] 0x9A returns bit byte2 of register byte1 in byte3.
// [R14] 0x9B clears or sets bit byte2 per byte3 and echoes.
// [R15] 0x9C applies direction byte3 to port byte1, returns value in byte2.
// [R16] 0x9D writes latch from byte2, direction from byte3, echoes.
// [R17] 0x9E sets pin direction from byte3, returns pin level in byte3.
// [R18] 0x9F sets pin latch from byte3 bit0, direction from bit1.
// [R19] 0x96 samples channel byte1[3:0], refs bits 4/5, result msb first.
// [R20] lower-index analog channels are high impedance during conversion.
// [R21] 0x93 mode 00 sets spi sampling and transmit edge from byte1.
// [R22] 0x93 byte2 sets enable, idle level and clock rate select.
// [R23] all responses of a report return together in one same-size report.
`timescale 1ns/1ps
module hrce_engine
  import hrce_pkg::*;
#(
  parameter int REPORT_BYTES = hrce_pkg::FULL_SPEED_REPORT_BYTES,
  parameter int NUM_PORTS = 5,
  parameter int NUM_ANALOG = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // report in from the endpoint
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  // report out to the endpoint
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // controller register bus
  output logic reg_re_o,
  output logic reg_we_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // general io ports
  input wire logic [NUM_PORTS*8-1:0] io_in_i,
  output logic [NUM_PORTS*8-1:0] io_out_o,
  output logic [NUM_PORTS*8-1:0] io_dir_o,
  // analog converter
  output logic adc_start_o,
  output logic [3:0] adc_chan_o,
  output logic adc_vref_pos_ext_o,
  output logic adc_vref_neg_ext_o,
  output logic [NUM_ANALOG-1:0] adc_hiz_o,
  input wire logic adc_done_i,
  input wire logic [9:0] adc_result_i,
  // synchronous serial unit setup
  output logic [7:0] spi_sampling_edge_setup_o,
  output logic [7:0] spi_enable_polarity_rate_o
);
  import hrce_pkg::*;

  localparam int AW = $clog2(REPORT_BYTES);
  localparam int PW = NUM_PORTS * 8;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hrce_state_e state;
    logic [AW-1:0] idx;
    logic [2:0] cnt;
    logic [3:0][7:0] cmd;
    logic [3:0][7:0] resp;
    logic [PW-1:0] io_out;
    logic [PW-1:0] io_dir;
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic [7:0] spi_stat;
    logic [7:0] spi_con;
    logic reg_re;
    logic reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic adc_start;
    logic [3:0] adc_chan;
    logic adc_pos;
    logic adc_neg;
    logic [NUM_ANALOG-1:0] adc_hiz;
    logic [7:0] tx_data;
    logic tx_valid;
    logic rx_ready;
  } hrce_state_s;

  hrce_state_s st_reg;
  hrce_state_s st_next;

  hrce_mem_if #(.AW(AW)) mem_bus ();

  hrce_report_mem #(.DEPTH(REPORT_BYTES)) u_mem (
    .mclk_i(mclk_i),
    .m(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic port_ok(input logic [7:0] num);
    port_ok = (num != 8'h00) && (int'(num) <= NUM_PORTS);
  endfunction

  function automatic int port_base(input logic [7:0] num);
    port_base = (int'(num) - 1) * 8;
  endfunction

  function automatic logic is_spi_reg(input logic [7:0] addr);
    is_spi_reg = (addr == SPI_SAMPLING_EDGE_SETUP_ADDR) ||
                 (addr == SPI_ENABLE_POLARITY_RATE_ADDR);
  endfunction

  function automatic logic [3:0][7:0] error_resp(
    input logic [3:0][7:0] c);
    error_resp = {c[2], c[1], c[0], CMD_ERROR};
  endfunction

  logic [AW-1:0] last_idx;
  assign last_idx = AW'(REPORT_BYTES - 1);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rv;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    int pb;
    rv = 8'h00;
    st_next = st_reg;
    b1 = st_reg.cmd[1];
    b2 = st_reg.cmd[2];
    b3 = st_reg.cmd[3];
    pb = port_base(b1);
    mem_bus.we = 1'b0;
    mem_bus.waddr = st_reg.idx;
    mem_bus.wdata = 8'h00;
    mem_bus.raddr = st_reg.idx;
    st_next.sync1 = io_in_i;
    st_next.sync2 = st_reg.sync1;
    st_next.reg_re = 1'b0;
    st_next.reg_we = 1'b0;
    st_next.adc_start = 1'b0;
    case (st_reg.state)
      ST_RX:
      begin
        // bytes land in the report buffer in arrival order
        if (rx_valid_i && st_reg.rx_ready)
        begin
          mem_bus.we = 1'b1;
          mem_bus.wdata = rx_data_i;
          st_next.idx = st_reg.idx + 1'b1;
          if (st_reg.idx == last_idx) // [R1] [R2]
          begin
            st_next.idx = '0;
            st_next.cnt = 3'h0;
            st_next.rx_ready = 1'b0;
            st_next.state = ST_FETCH;
          end
        end
      end
      ST_FETCH:
      begin
        // one read in flight; data lands a cycle after its address
        mem_bus.raddr = st_reg.idx + AW'(st_reg.cnt);
        if (st_reg.cnt != 3'h0)
        begin
          st_next.cmd[st_reg.cnt - 3'h1] = mem_bus.rdata;
        end
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == 3'(CMD_BYTES))
        begin
          st_next.cnt = 3'h0;
          st_next.state = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        st_next.resp = st_reg.cmd; // [R9] [R8]
        st_next.state = ST_WB;
        case (st_reg.cmd[0]) // [R6]
          CMD_NULL:
          begin
            st_next.resp = '0; // [R10]
          end
          READ_REG_CMD, READ_REG_BIT_CMD, WRITE_REG_BIT_CMD:
          begin
            if (st_reg.cmd[0] != READ_REG_CMD && b2 > 8'h07)
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
            else if (st_reg.cmd[0] == WRITE_REG_BIT_CMD && b3 > 8'h01)
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
            else
            begin
              st_next.reg_addr = b1;
              st_next.reg_re = !is_spi_reg(b1);
              st_next.cnt = 3'h0;
              st_next.state = ST_RDWAIT;
            end
          end
          WRITE_REG_CMD:
          begin
            // unimplemented setup bits always read back as zero
            if (b1 == SPI_SAMPLING_EDGE_SETUP_ADDR) // [R12]
            begin
              st_next.spi_stat = b2 & SPI_SAMPLING_EDGE_SETUP_MASK;
            end
            else if (b1 == SPI_ENABLE_POLARITY_RATE_ADDR)
            begin
              st_next.spi_con = b2 & SPI_ENABLE_POLARITY_RATE_MASK;
            end
            else
            begin
              st_next.reg_addr = b1;
              st_next.reg_wdata = b2;
              st_next.reg_we = 1'b1; // [R12]
            end
          end
          READ_IO_CMD, WRITE_IO_CMD:
          begin
            if (!port_ok(b1))
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
            else
            begin
              st_next.io_dir[pb +: 8] = b3; // [R15] [R16]
              if (st_reg.cmd[0] == WRITE_IO_CMD)
              begin
                st_next.io_out[pb +: 8] = b2; // [R16]
              end
              else
              begin
                st_next.resp[2] = st_reg.sync2[pb +: 8]; // [R15]
              end
            end
          end
          READ_IO_PIN_CMD, WRITE_IO_PIN_CMD:
          begin
            if (!port_ok(b1) || b2 > 8'h07)
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
            else if (st_reg.cmd[0] == READ_IO_PIN_CMD)
            begin
              st_next.io_dir[pb + int'(b2[2:0])] = b3[0]; // [R17]
              st_next.resp[3] = {7'h00, st_reg.sync2[pb + int'(b2[2:0])]};
            end
            else
            begin
              st_next.io_out[pb + int'(b2[2:0])] = b3[0]; // [R18]
              st_next.io_dir[pb + int'(b2[2:0])] = b3[1]; // [R18]
            end
          end
          ANALOG_SAMPLE_CMD:
          begin
            if (int'(b1[3:0]) >= NUM_ANALOG)
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
            else
            begin
              st_next.adc_chan = b1[3:0]; // [R19]
              st_next.adc_pos = b1[ADC_VREF_POS_BIT];
              st_next.adc_neg = b1[ADC_VREF_NEG_BIT];
              for (int i = 0; i < NUM_ANALOG; i++)
              begin
                st_next.adc_hiz[i] = (i < int'(b1[3:0])); // [R20]
              end
              st_next.adc_start = 1'b1;
              st_next.state = ST_ADC;
            end
          end
          SERIAL_SETUP_CMD:
          begin
            // only the spi flavour lives here; other modes are refused
            if (b1[1:0] == SERIAL_MODE_SPI)
            begin
              st_next.spi_stat = b1 & SPI_SAMPLING_EDGE_SETUP_MASK; // [R21]
              st_next.spi_con = b2 & SPI_ENABLE_POLARITY_RATE_MASK; // [R22]
            end
            else
            begin
              st_next.resp = error_resp(st_reg.cmd);
            end
          end
          default:
          begin
            st_next.resp = error_resp(st_reg.cmd); // [R11]
          end
        endcase
      end
      ST_RDWAIT:
      begin
        // external read data is valid the cycle after the strobe
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == 3'h1)
        begin
          if (st_reg.reg_addr == SPI_SAMPLING_EDGE_SETUP_ADDR)
          begin
            rv = st_reg.spi_stat;
          end
          else if (st_reg.reg_addr == SPI_ENABLE_POLARITY_RATE_ADDR)
          begin
            rv = st_reg.spi_con;
          end
          else
          begin
            rv = reg_rdata_i;
          end
          st_next.cnt = 3'h0;
          st_next.state = ST_WB;
          if (st_reg.cmd[0] == READ_REG_CMD)
          begin
            st_next.resp[2] = rv; // [R12]
          end
          else if (st_reg.cmd[0] == READ_REG_BIT_CMD)
          begin
            st_next.resp[3] = {7'h00, rv[b2[2:0]]}; // [R13]
          end
          else
          begin
            rv[b2[2:0]] = b3[0]; // [R14]
            if (st_reg.reg_addr == SPI_SAMPLING_EDGE_SETUP_ADDR)
            begin
              st_next.spi_stat = rv & SPI_SAMPLING_EDGE_SETUP_MASK;
            end
            else if (st_reg.reg_addr == SPI_ENABLE_POLARITY_RATE_ADDR)
            begin
              st_next.spi_con = rv & SPI_ENABLE_POLARITY_RATE_MASK;
            end
            else
            begin
              st_next.reg_wdata = rv;
              st_next.reg_we = 1'b1;
            end
          end
        end
      end
      ST_ADC:
      begin
        if (adc_done_i)
        begin
          st_next.resp[2] = {6'h00, adc_result_i[9:8]}; // [R19]
          st_next.resp[3] = adc_result_i[7:0];
          st_next.adc_hiz = '0; // [R20]
          st_next.state = ST_WB;
        end
      end
      ST_WB:
      begin
        // answer goes back into the same slot it came from
        mem_bus.we = 1'b1;
        mem_bus.waddr = st_reg.idx + AW'(st_reg.cnt);
        mem_bus.wdata = st_reg.resp[st_reg.cnt[1:0]];
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == 3'(CMD_BYTES - 1))
        begin
          st_next.cnt = 3'h0;
          st_next.idx = st_reg.idx + AW'(CMD_BYTES); // [R5] [R3]
          st_next.state = ST_FETCH;
          if (st_reg.idx == last_idx - AW'(CMD_BYTES - 1))
          begin
            st_next.idx = '0;
            st_next.state = ST_TXRD; // [R23]
          end
        end
      end
      ST_TXRD:
      begin
        st_next.state = ST_TXLD;
      end
      ST_TXLD:
      begin
        st_next.tx_data = mem_bus.rdata;
        st_next.tx_valid = 1'b1;
        st_next.state = ST_TXOUT;
      end
      ST_TXOUT:
      begin
        if (tx_ready_i)
        begin
          st_next.tx_valid = 1'b0;
          st_next.idx = st_reg.idx + 1'b1;
          st_next.state = ST_TXRD;
          if (st_reg.idx == last_idx) // [R23]
          begin
            st_next.idx = '0;
            st_next.rx_ready = 1'b1;
            st_next.state = ST_RX;
          end
        end
      end
      default:
      begin
        st_next.state = ST_RX;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_reg <= '0;
      st_reg.state <= ST_RX;
      st_reg.rx_ready <= 1'b1;
      st_reg.io_dir <= {NUM_PORTS{IO_DIR_RESET}};
      st_reg.io_out <= {NUM_PORTS{IO_OUT_RESET}};
      st_reg.spi_stat <= SPI_SAMPLING_EDGE_SETUP_RESET;
      st_reg.spi_con <= SPI_ENABLE_POLARITY_RATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rx_ready_o = st_reg.rx_ready;
  assign tx_valid_o = st_reg.tx_valid;
  assign tx_data_o = st_reg.tx_data;
  assign reg_re_o = st_reg.reg_re;
  assign reg_we_o = st_reg.reg_we;
  assign reg_addr_o = st_reg.reg_addr;
  assign reg_wdata_o = st_reg.reg_wdata;
  assign io_out_o = st_reg.io_out;
  assign io_dir_o = st_reg.io_dir;
  assign adc_start_o = st_reg.adc_start;
  assign adc_chan_o = st_reg.adc_chan;
  assign adc_vref_pos_ext_o = st_reg.adc_pos;
  assign adc_vref_neg_ext_o = st_reg.adc_neg;
  assign adc_hiz_o = st_reg.adc_hiz;
  assign spi_sampling_edge_setup_o = st_reg.spi_stat;
  assign spi_enable_polarity_rate_o = st_reg.spi_con;

endmodule // hrce_engine

/* File: test/hrce_engine_sva.sv */
`timescale 1ns/1ps
module hrce_engine_sva
  import hrce_pkg::*;
#(
  parameter int REPORT_BYTES = 64,
  parameter int NUM_ANALOG = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // report streams
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // register bus and converter
  input wire logic reg_re_o,
  input wire logic reg_we_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic adc_start_o,
  input wire logic [3:0] adc_chan_o,
  input wire logic [NUM_ANALOG-1:0] adc_hiz_o,
  input wire logic adc_done_i,
  // serial setup
  input wire logic [7:0] spi_sampling_edge_setup_o,
  input wire logic [7:0] spi_enable_polarity_rate_o
);
  int rx_cnt_reg;
  int tx_cnt_reg;
  logic [NUM_ANALOG-1:0] hiz_exp;

  // channels below the measured one float
  assign hiz_exp = (NUM_ANALOG'(1) << adc_chan_o) - NUM_ANALOG'(1);

  // counters restart at each phase change of the engine
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_cnt_reg <= 0;
      tx_cnt_reg <= 0;
    end
    else
    begin
      rx_cnt_reg <= !rx_ready_o ? 0 : rx_cnt_reg + int'(rx_valid_i);
      tx_cnt_reg <= rx_ready_o ? 0
                  : tx_cnt_reg + int'(tx_valid_o && tx_ready_i);
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_tx_hs;
    tx_valid_o && tx_ready_i;
  endsequence
  sequence s_tx_last;
    s_tx_hs ##0 (tx_cnt_reg == REPORT_BYTES - 1);
  endsequence

  chk_rx_full:
  assert property (rx_cnt_reg == REPORT_BYTES |-> !rx_ready_o)
    else $error("report input not closed after a full report");
  chk_tx_after_rx:
  assert property (tx_valid_o |-> !rx_ready_o)
    else $error("response byte offered while taking commands");
  chk_tx_last_byte:
  assert property (s_tx_last |=> rx_ready_o && !tx_valid_o)
    else $error("input not reopened after last response byte");
  chk_tx_held:
  assert property (tx_valid_o && !tx_ready_i
                   |=> tx_valid_o && $stable(tx_data_o))
    else $error("response byte changed before it was taken");
  chk_reg_internal:
  assert property (reg_re_o || reg_we_o |->
                   !(reg_re_o && reg_we_o)
                   && reg_addr_o != SPI_SAMPLING_EDGE_SETUP_ADDR
                   && reg_addr_o != SPI_ENABLE_POLARITY_RATE_ADDR)
    else $error("bad strobe on the register bus");
  chk_hiz_start:
  assert property (adc_start_o |-> adc_hiz_o == hiz_exp ##1 !adc_start_o)
    else $error("wrong float mask at conversion start");
  chk_hiz_hold:
  assert property (adc_hiz_o != '0 && !adc_done_i |=> $stable(adc_hiz_o))
    else $error("float mask changed during conversion");
  chk_hiz_release:
  assert property (adc_done_i && adc_hiz_o != '0 |=> adc_hiz_o == '0)
    else $error("float mask not released after conversion");
  chk_spi_fields:
  assert property (
    (spi_sampling_edge_setup_o & ~SPI_SAMPLING_EDGE_SETUP_MASK) == 8'h00
    && (spi_enable_polarity_rate_o & ~SPI_ENABLE_POLARITY_RATE_MASK)
       == 8'h00)
    else $error("reserved serial setup bits set");
endmodule // hrce_engine_sva

bind hrce_engine hrce_engine_sva #(
  .REPORT_BYTES(REPORT_BYTES),
  .NUM_ANALOG(NUM_ANALOG)
) u_sva (
  .mclk_i, .resetn_i, .rx_valid_i, .rx_ready_o, .tx_valid_o, .tx_data_o,
  .tx_ready_i, .reg_re_o, .reg_we_o, .reg_addr_o, .adc_start_o,
  .adc_chan_o, .adc_hiz_o, .adc_done_i, .spi_sampling_edge_setup_o,
  .spi_enable_polarity_rate_o
);

/* File: test/hrce_periph_model.sv */
`timescale 1ns/1ps
module hrce_periph_model #(
  parameter logic [39:0] EXT_LEVELS = 40'hC396A55A3C
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic reg_re_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // pins
  input wire logic [39:0] io_out_i,
  input wire logic [39:0] io_dir_i,
  output logic [39:0] io_in_o,
  // converter
  input wire logic adc_start_i,
  input wire logic [3:0] adc_chan_i,
  output logic adc_done_o,
  output logic [9:0] adc_result_o
);
  logic [7:0] regs [256];
  logic [2:0] wait_reg;

  // inputs see the outside pattern, outputs read back their latch
  assign io_in_o = (io_dir_i & EXT_LEVELS) | (~io_dir_i & io_out_i);

  // idle buses scramble so stale data cannot pass as an answer
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      wait_reg <= 3'h0;
      adc_done_o <= 1'b0;
      adc_result_o <= 10'h000;
    end
    else
    begin
      reg_rdata_o <= reg_re_i ? regs[reg_addr_i] : ~reg_rdata_o;
      if (reg_we_i)
        regs[reg_addr_i] <= reg_wdata_i;
      wait_reg <= adc_start_i ? 3'h5 : wait_reg - 3'(wait_reg != 3'h0);
      adc_done_o <= (wait_reg == 3'h1);
      adc_result_o <= (wait_reg == 3'h1) ? {adc_chan_i, 6'h2A}
                                         : ~adc_result_o;
    end
  end
endmodule // hrce_periph_model

/* File: test/hid_report_command_engine_tb.sv */
`timescale 1ns/1ps
module hid_report_command_engine_tb;
  import hrce_pkg::*;
  localparam int RB = 8;
  localparam logic [39:0] EXT = 40'hC396A55A3C;
  logic mclk_i, resetn_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic [7:0] rx_data_i, tx_data_o, reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic reg_re_o, reg_we_o, adc_start_o, adc_done_i;
  logic adc_vref_pos_ext_o, adc_vref_neg_ext_o;
  logic [39:0] io_in_i, io_out_o, io_dir_o;
  logic [3:0] adc_chan_o;
  logic [15:0] adc_hiz_o;
  logic [9:0] adc_result_i;
  logic [7:0] spi_sampling_edge_setup_o, spi_enable_polarity_rate_o;
  int n_errors, n_compared, cycles;

  hrce_engine #(.REPORT_BYTES(RB)) DUT (
    .mclk_i, .resetn_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
    .tx_valid_o, .tx_data_o, .tx_ready_i, .reg_re_o, .reg_we_o,
    .reg_addr_o, .reg_wdata_o, .reg_rdata_i, .io_in_i, .io_out_o,
    .io_dir_o, .adc_start_o, .adc_chan_o, .adc_vref_pos_ext_o,
    .adc_vref_neg_ext_o, .adc_hiz_o, .adc_done_i, .adc_result_i,
    .spi_sampling_edge_setup_o, .spi_enable_polarity_rate_o);

  hrce_periph_model #(.EXT_LEVELS(EXT)) u_periph (
    .mclk_i, .resetn_i, .reg_re_i(reg_re_o), .reg_we_i(reg_we_o),
    .reg_addr_i(reg_addr_o), .reg_wdata_i(reg_wdata_o),
    .reg_rdata_o(reg_rdata_i), .io_out_i(io_out_o), .io_dir_i(io_dir_o),
    .io_in_o(io_in_i), .adc_start_i(adc_start_o), .adc_chan_i(adc_chan_o),
    .adc_done_o(adc_done_i), .adc_result_o(adc_result_i));

  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t ns got %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait on rx ready (0) or tx valid (1), looked at off the edge
  task wait_hi(input bit sel);
    int n;
    n = 0;
    while ((sel ? tx_valid_o : rx_ready_o) !== 1'b1 && n < 300)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 300)
    begin
      n_errors++;
      $display("[FAIL] %0t ns handshake wait limit reached", $time);
    end
  endtask

  // byte 0 of a report is the leftmost byte of the literal
  task xfer(input logic [63:0] c, input logic [63:0] e, input bit stall);
    int k;
    for (k = 0; k < RB; k++)
    begin
      rx_valid_i = 1'b1;
      rx_data_i = c[63-8*k -: 8];
      wait_hi(1'b0);
      @(posedge mclk_i);
      #1;
    end
    rx_valid_i = 1'b0;
    for (k = 0; k < RB; k++)
    begin
      wait_hi(1'b1);
      if (stall)
      begin
        tx_ready_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        tx_ready_i = 1'b1;
      end
      check(tx_data_o, e[63-8*k -: 8]);
      @(posedge mclk_i);
      #1;
    end
  endtask

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] b1, b2;
    int i;
    resetn_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    tx_ready_i = 1'b1;
    repeat (16) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    xfer(64'h98E01122_00123456, 64'h98E00022_00000000, 1);
    $display("test reset and null done");
    xfer(64'h12345678_99405A77, 64'hFF123456_99405A77, 0);
    xfer(64'h98400033_9A400100, 64'h98405A33_9A400101, 0);
    xfer(64'h9B400001_98400000, 64'h9B400001_98405B00, 0);
    xfer(64'h9A400800_9B400202, 64'hFF9A4008_FF9B4002, 0);
    xfer(64'h99E1FF00_98E10000, 64'h99E1FF00_98E13300, 0);
    xfer(64'hAF034567_00000000, 64'hFFAF0345_00000000, 0);
    $display("test register commands done");
    for (i = 0; i < 4; i++)
    begin
      b1 = {i[1:0], 6'h00};
      b2 = {2'h0, 1'b1, i[0], 2'h0, i[1:0]};
      xfer({8'h93, b1, b2, 8'h00, 32'h98E10000},
           {8'h93, b1, b2, 8'h00, 8'h98, 8'hE1, b2, 8'h00}, 0);
      check(spi_sampling_edge_setup_o, b1);
      check(spi_enable_polarity_rate_o, b2);
    end
    xfer(64'h93013B00_00000000, 64'hFF93013B_00000000, 0);
    $display("test serial setup done");
    xfer(64'h9D02540F_9C02000F,
         {40'h9D02540F_9C, 8'h02, (8'h0F & EXT[15:8]) | 8'h50, 8'h0F},
         0);
    check(io_out_o[15:8], 8'h54);
    check(io_dir_o[15:8], 8'h0F);
    xfer(64'h9C0000FF_9D061100, 64'hFF9C0000_FF9D0611, 0);
    xfer(64'h9F030501_9E030500, 64'h9F030501_9E030501, 0);
    check({6'h00, io_out_o[21], io_dir_o[21]}, 8'h02);
    xfer(64'h9F030200_9E030201, 64'h9F030200_9E030200, 0);
    check({7'h00, io_dir_o[18]}, 8'h01);
    $display("test ports done");
    xfer(64'h96160000_962F0000, 64'h961601AA_962F03EA, 1);
    check({6'h00, adc_vref_neg_ext_o, adc_vref_pos_ext_o}, 8'h02);
    $display("test analog done");
    final_report;
  end
endmodule // hid_report_command_engine_tb
